// File: hdl/brownout_poweron_monitor.sv
// Operation
// - enabled brownout without interrupt routing resets the processor.
// - select bit plus both interrupt enables turn brownout into an interrupt request.
// - unprogrammed configuration bit keeps detection off regardless of other bits.
// - power mode 11 disables detection even when configuration bit programmed.
// - powerdown bit 1 disables detection; it resets to 0.
// - brownout condition follows the comparator while detection is enabled.
// - every detected brownout sets the brownout flag, whatever the routing.
// - brownout flag stays set until software writes zero to it.
// - power-on with configuration programmed sets brownout flag with power-on flag.
// - interrupt only when select, brownout enable and global enable are set.
// - select with an enable off gives no reset, no interrupt, flag set.
// - power-on detector sets power-on flag before brownout detection operates.
// - power-on flag stays set until software writes zero to it.
// - brownout flag is meaningless when configuration bit unprogrammed.
// - mode field 00 normal (default), 01 idle, 10 power-down.
`timescale 1ns/1ps
`default_nettype none
`include "bpm_params.svh"
module brownout_poweron_monitor #(
  parameter int STARTUP_CYCLES = `BPM_STARTUP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic brownout_cfg_enable,
  input wire logic supply_low,
  input wire logic pctl_wr,
  input wire bpm_pkg::power_ctrl_s pctl_wdata,
  input wire logic ien_wr,
  input wire bpm_pkg::irq_en_s ien_wdata,
  input wire logic flag_wr,
  input wire bpm_pkg::rst_src_s flag_wdata,
  output bpm_pkg::power_ctrl_s pctl_rdata,
  output bpm_pkg::irq_en_s ien_rdata,
  output bpm_pkg::rst_src_s flag_rdata,
  output logic detect_active,
  output logic brownout_cond,
  output logic cpu_reset_req,
  output logic brownout_irq
);
  if (STARTUP_CYCLES < 3 || STARTUP_CYCLES > 255) begin : g_bad_startup
    $error("STARTUP_CYCLES must lie between 3 and 255");
  end

  // ***************************
  // input synchronisers
  // ***************************
  logic cfg_m_q, cfg_q, low_m_q, low_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_m_q <= 1'b0;
      cfg_q <= 1'b0;
      low_m_q <= 1'b0;
      low_q <= 1'b0;
    end else begin
      cfg_m_q <= brownout_cfg_enable;
      cfg_q <= cfg_m_q;
      low_m_q <= supply_low;
      low_q <= low_m_q;
    end
  end

  // ***************************
  // software control bits
  // ***************************
  bpm_pkg::power_ctrl_s pctl_q;
  bpm_pkg::irq_en_s ien_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pctl_q.power_mode_field <= `BPM_MODE_RST;
      pctl_q.brownout_powerdown <= `BPM_BROWNOUT_POWERDOWN_RST;
      pctl_q.brownout_irq_select <= `BPM_SEL_RST;
    end else if (pctl_wr) begin
      pctl_q <= pctl_wdata;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ien_q <= '{global_irq_enable: `BPM_IEN_RST, brownout_irq_enable: `BPM_IEN_RST};
    end else if (ien_wr) begin
      ien_q <= ien_wdata;
    end
  end
  assign pctl_rdata = pctl_q;
  assign ien_rdata = ien_q;

  // ***************************
  // power-on phase
  // ***************************
  bpm_pkg::phase_e phase_q;
  logic [7:0] start_cnt_q;
  logic po_event;
  assign po_event = (phase_q == bpm_pkg::ST_STARTUP) && (start_cnt_q == 8'(STARTUP_CYCLES - 1));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= bpm_pkg::ST_STARTUP;
      start_cnt_q <= 8'h00;
    end else begin
      unique case (phase_q)
        bpm_pkg::ST_STARTUP: begin
          start_cnt_q <= start_cnt_q + 8'h01;
          if (po_event) begin
            phase_q <= bpm_pkg::ST_RUN;
          end
        end
        bpm_pkg::ST_RUN: begin
          start_cnt_q <= start_cnt_q;
        end
        default: begin
          phase_q <= bpm_pkg::ST_STARTUP;
        end
      endcase
    end
  end

  // ***************************
  // detection and routing
  // ***************************
  logic det_en, det_hit;
  assign det_en = cfg_q && (pctl_q.power_mode_field != `BPM_MODE_TOTAL) && !pctl_q.brownout_powerdown
                  && (phase_q == bpm_pkg::ST_RUN);
  assign det_hit = det_en && low_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      detect_active <= 1'b0;
      brownout_cond <= 1'b0;
      cpu_reset_req <= 1'b0;
      brownout_irq <= 1'b0;
    end else begin
      detect_active <= det_en;
      brownout_cond <= det_hit;
      cpu_reset_req <= det_hit && !pctl_q.brownout_irq_select;
      brownout_irq <= det_hit && pctl_q.brownout_irq_select && ien_q.brownout_irq_enable
                      && ien_q.global_irq_enable;
    end
  end

  // ***************************
  // sticky flags
  // ***************************
  bpm_pkg::rst_src_s flag_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= '{brownout_flag: 1'b0, poweron_flag: 1'b0};
    end else begin
      if (det_hit || (po_event && cfg_q)) begin
        flag_q.brownout_flag <= 1'b1;
      end else if (flag_wr && !flag_wdata.brownout_flag) begin
        flag_q.brownout_flag <= 1'b0;
      end
      if (po_event) begin
        flag_q.poweron_flag <= 1'b1;
      end else if (flag_wr && !flag_wdata.poweron_flag) begin
        flag_q.poweron_flag <= 1'b0;
      end
    end
  end
  assign flag_rdata = flag_q;

  // ***************************
  // checks
  // ***************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_cfg_off_quiet: assert property (!cfg_q |=> !brownout_cond && !cpu_reset_req && !brownout_irq)
    else $error("detection acted with configuration bit off");
  chk_total_pd_quiet: assert property (pctl_q.power_mode_field == `BPM_MODE_TOTAL |=> !detect_active)
    else $error("detection active in total power-down");
  chk_brownout_powerdown_quiet: assert property (pctl_q.brownout_powerdown |=> !brownout_cond)
    else $error("detection active with powerdown bit set");
  chk_reset_route: assert property (det_hit && !pctl_q.brownout_irq_select |=> cpu_reset_req)
    else $error("brownout did not reset");
  chk_irq_route: assert property (brownout_irq |-> $past(pctl_q.brownout_irq_select)
    && $past(ien_q.brownout_irq_enable) && $past(ien_q.global_irq_enable))
    else $error("interrupt without full enable");
  chk_no_both: assert property (!(cpu_reset_req && brownout_irq))
    else $error("reset and interrupt together");
  chk_irq_blocked: assert property (pctl_q.brownout_irq_select
    && !(ien_q.brownout_irq_enable && ien_q.global_irq_enable) |=> !brownout_irq && !cpu_reset_req)
    else $error("blocked interrupt routing still acted");
  chk_cond_follow: assert property (det_en && low_q |=> brownout_cond && flag_q.brownout_flag)
    else $error("brownout not seen or not flagged");
  chk_cond_drop: assert property (det_en && !low_q |=> !brownout_cond && !cpu_reset_req && !brownout_irq)
    else $error("brownout condition held with supply good");
  chk_bof_sticky: assert property (flag_q.brownout_flag && !(flag_wr && !flag_wdata.brownout_flag)
    |=> flag_q.brownout_flag)
    else $error("brownout flag lost");
  chk_pof_sticky: assert property (flag_q.poweron_flag && !(flag_wr && !flag_wdata.poweron_flag)
    |=> flag_q.poweron_flag)
    else $error("power-on flag lost");
  chk_bof_clear: assert property (flag_wr && !flag_wdata.brownout_flag && !det_hit
    && !(po_event && cfg_q) |=> !flag_q.brownout_flag)
    else $error("brownout flag not cleared by zero write");
  chk_pof_clear: assert property (flag_wr && !flag_wdata.poweron_flag && !po_event |=> !flag_q.poweron_flag)
    else $error("power-on flag not cleared by zero write");
  chk_bof_only_hw: assert property (!flag_q.brownout_flag && !det_hit && !(po_event && cfg_q)
    |=> !flag_q.brownout_flag)
    else $error("brownout flag set without an event");
  chk_pof_only_hw: assert property (!flag_q.poweron_flag && !po_event |=> !flag_q.poweron_flag)
    else $error("power-on flag set without an event");
  chk_ctrl_readback: assert property (pctl_wr |=> pctl_rdata == $past(pctl_wdata))
    else $error("power control bits not stored");
  chk_ien_readback: assert property (ien_wr |=> ien_rdata == $past(ien_wdata))
    else $error("interrupt enable bits not stored");
  chk_po_both: assert property (po_event && cfg_q |=> flag_q.poweron_flag && flag_q.brownout_flag)
    else $error("power-on flags not set together");
  chk_po_first: assert property (phase_q == bpm_pkg::ST_STARTUP |-> !detect_active)
    else $error("detection before power-on done");
  chk_po_flag_run: assert property ($rose(phase_q == bpm_pkg::ST_RUN) |-> flag_q.poweron_flag)
    else $error("run phase without power-on flag");
  chk_run_stays: assert property (phase_q == bpm_pkg::ST_RUN |=> phase_q == bpm_pkg::ST_RUN)
    else $error("run phase left without reset");

  cov_reset: cover property (cpu_reset_req);
  cov_irq: cover property (brownout_irq);
  cov_flag_only: cover property (brownout_cond && !cpu_reset_req && !brownout_irq);
  cov_clear: cover property (flag_q.brownout_flag ##1 !flag_q.brownout_flag);
  cov_poweron: cover property (po_event && cfg_q);
endmodule
`default_nettype wire

// File: inc/bpm_params.svh
`ifndef BPM_PARAMS_SVH
`define BPM_PARAMS_SVH
// power mode field encodings
`define BPM_MODE_NORMAL 2'h0
`define BPM_MODE_IDLE 2'h1
`define BPM_MODE_PDOWN 2'h2
`define BPM_MODE_TOTAL 2'h3
// reset values of the software bits
`define BPM_MODE_RST 2'h0
`define BPM_BROWNOUT_POWERDOWN_RST 1'h0
`define BPM_SEL_RST 1'h0
`define BPM_IEN_RST 1'h0
// field positions in the reset source bits
`define BPM_FLAG_BO_POS 1
`define BPM_FLAG_PO_POS 0
// power-on settle time before detection may act
`define BPM_STARTUP_CYCLES 3
`endif

// File: inc/bpm_pkg.sv
package bpm_pkg;
  typedef struct packed {
    logic brownout_powerdown;
    logic brownout_irq_select;
    logic [1:0] power_mode_field;
  } power_ctrl_s;
  typedef struct packed {
    logic global_irq_enable;
    logic brownout_irq_enable;
  } irq_en_s;
  typedef struct packed {
    logic brownout_flag;
    logic poweron_flag;
  } rst_src_s;
  typedef enum logic [1:0] {ST_STARTUP, ST_RUN} phase_e;
endpackage

// File: verif/brownout_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// core reset and interrupt side
// ****************
module brownout_core_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cpu_reset_req,
  input wire logic brownout_irq,
  input wire logic seen_clr,
  output logic seen_reset_q,
  output logic seen_irq_q
);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen_reset_q <= 1'b0;
      seen_irq_q <= 1'b0;
    end else if (seen_clr) begin
      seen_reset_q <= 1'b0;
      seen_irq_q <= 1'b0;
    end else begin
      seen_reset_q <= seen_reset_q | cpu_reset_req;
      seen_irq_q <= seen_irq_q | brownout_irq;
    end
  end
endmodule
`default_nettype wire

// File: verif/brownout_poweron_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
// ****************
// bench
// ****************
module brownout_poweron_monitor_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cfg = 1'b1;
  logic low = 1'b0;
  logic pwr = 1'b0;
  logic iwr = 1'b0;
  logic fwr = 1'b0;
  logic clr = 1'b0;
  bpm_pkg::power_ctrl_s pw = 4'h0;
  bpm_pkg::irq_en_s iw = 2'h0;
  bpm_pkg::rst_src_s fw = 2'h0;
  bpm_pkg::power_ctrl_s pr;
  bpm_pkg::irq_en_s ir;
  bpm_pkg::rst_src_s fr;
  logic det, cond, rr, irq, sr, si;
  int err_total = 0;
  int n_checks = 0;
  // cfg, powerdown, select, mode[1:0], global, enable -> active, reset, irq
  logic [9:0] rows [9] = '{10'b1000000110, 10'b1010011101, 10'b1010001100, 10'b1010010100,
    10'b0000011000, 10'b1001111000, 10'b1100011000, 10'b1000100110, 10'b1001000110};
  brownout_poweron_monitor #(.STARTUP_CYCLES(3)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .brownout_cfg_enable(cfg), .supply_low(low), .pctl_wr(pwr), .pctl_wdata(pw), .ien_wr(iwr),
    .ien_wdata(iw), .flag_wr(fwr), .flag_wdata(fw), .pctl_rdata(pr), .ien_rdata(ir),
    .flag_rdata(fr), .detect_active(det), .brownout_cond(cond), .cpu_reset_req(rr),
    .brownout_irq(irq));
  brownout_core_model core (.clk_sys(clk_sys), .rst_b(rst_b), .cpu_reset_req(rr),
    .brownout_irq(irq), .seen_clr(clr), .seen_reset_q(sr), .seen_irq_q(si));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wflag(input logic [1:0] v);
    @(posedge clk_sys);
    fw <= v;
    fwr <= 1'b1;
    @(posedge clk_sys);
    fwr <= 1'b0;
    cyc(1);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(6);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      cfg <= rows[i][9];
      pw <= rows[i][8:5];
      iw <= rows[i][4:3];
      pwr <= 1'b1;
      iwr <= 1'b1;
      clr <= 1'b1;
      @(posedge clk_sys);
      pwr <= 1'b0;
      iwr <= 1'b0;
      clr <= 1'b0;
      cyc(4);
      `CHK({pr, ir}, rows[i][8:3])
      wflag(2'h0);
      @(posedge clk_sys);
      low <= 1'b1;
      cyc(4);
      `CHK(det, rows[i][2])
      `CHK(cond, rows[i][2])
      `CHK({rr, sr}, {2{rows[i][1]}})
      `CHK({irq, si}, {2{rows[i][0]}})
      wflag(2'h0);
      if (rows[i][2]) `CHK(fr.brownout_flag, 1'b1)
      @(posedge clk_sys);
      low <= 1'b0;
      cyc(4);
      `CHK({cond, rr, irq}, 3'h0)
    end
    @(posedge clk_sys);
    rst_b <= 1'b0;
    cyc(2);
    `CHK({det, rr, irq, pr, ir, fr}, 11'h000)
    @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(6);
    `CHK(fr, 2'h3)
    wflag(2'h3);
    `CHK(fr, 2'h3)
    wflag(2'h1);
    `CHK(fr, 2'h1)
    cyc(5);
    `CHK(fr, 2'h1)
    wflag(2'h2);
    `CHK(fr, 2'h0)
    summarize();
  end
endmodule
`default_nettype wire
